// ==== rtl/dpa_pkg.sv ====
package dpa_pkg;
    // Register offsets on the configuration port
    localparam logic [7:0] REG_SLOPE  = 8'h25;  // Slope select
    localparam logic [7:0] REG_RUN    = 8'h26;  // Run and readback control
    localparam logic [7:0] REG_PHASE  = 8'h27;  // Target phase, mode, tap bit 0
    localparam logic [7:0] REG_TAP    = 8'h28;  // Initial tap bits 8:1
    localparam logic [7:0] REG_GUARD  = 8'h29;  // Guard, loss and retry policy
    localparam logic [7:0] REG_STATUS = 8'h2A;  // Lock status, read only

    // Field positions
    localparam int SLOPE_NEG_BIT = 7;  // 1 = negative slope wanted
    localparam int RUN_BIT       = 0;  // Enables the search state machine
    localparam int READ_BIT      = 3;  // Read back live tap in REG_TAP and REG_PHASE
    localparam int TAP_LSB_BIT   = 7;  // Tap bit 0 inside REG_PHASE
    localparam int TRACK_BIT     = 6;  // Track after search
    localparam int LOSS_BIT      = 5;  // restart_on_loss
    localparam int RETRY_BIT     = 6;  // Retry a failed search

    // Values after reset
    localparam logic [7:0] RST_SLOPE = 8'h80;
    localparam logic [7:0] RST_RUN   = 8'h00;
    localparam logic [7:0] RST_PHASE = 8'h46;
    localparam logic [7:0] RST_TAP   = 8'h6C;
    localparam logic [7:0] RST_GUARD = 8'hCB;

    // Delay line and phase scaling
    localparam logic [8:0] TAP_MAX     = 9'h1B0;  // Top tap, 864 ps span at 2 ps
    localparam int         GUARD_SHIFT = 3;       // One guard step is eight taps
    localparam logic [4:0] PHASE_HALF  = 5'h10;   // Phase code for 180 degrees
    localparam logic [4:0] LOSE_STEPS  = 5'h04;   // Drift beyond this drops lock
    localparam logic [4:0] KEEP_STEPS  = 5'h03;   // Drift within this regains lock

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEARCH,
        ST_SLOPE,
        ST_TRACK,
        ST_FAIL
    } dpa_state_t;
endpackage

// ==== rtl/dpa_eval_if.sv ====
`timescale 1ns/10ps
interface dpa_eval_if;
    logic [4:0] meas;      // Measured phase
    logic [4:0] target;    // Programmed phase
    logic [4:0] prev;      // Phase one tap below
    logic [4:0] diff;      // Signed measured minus target
    logic       far;       // More than the lose threshold away
    logic       near;      // Within the keep threshold
    logic       exact;     // Measured equals target
    logic       slope_dn;  // Phase fell from prev to meas
    logic       slope_up;  // Phase rose from prev to meas
    modport ctl  (output meas, target, prev, input diff, far, near, exact, slope_dn, slope_up);
    modport eval (input meas, target, prev, output diff, far, near, exact, slope_dn, slope_up);
endinterface

// ==== rtl/dpa_phase_eval.sv ====
`timescale 1ns/10ps
module dpa_phase_eval
    import dpa_pkg::*;
(
    dpa_eval_if.eval ev
);
    // Magnitude of a signed phase step, wrapping at a full turn
    function automatic logic [4:0] mag5(input logic [4:0] d);
        mag5 = d[4] ? 5'(~d + 5'h01) : d;
    endfunction

    logic [4:0] step;  // Phase change across one tap

    // Differences wrap modulo 32, so 16 is half a turn either way
    always_comb begin
        ev.diff     = 5'(ev.meas - ev.target);
        step        = 5'(ev.meas - ev.prev);
        ev.exact    = (ev.diff == 5'h00);
        ev.far      = (mag5(ev.diff) > LOSE_STEPS);
        ev.near     = (mag5(ev.diff) <= KEEP_STEPS);
        ev.slope_dn = step[4] && (step != PHASE_HALF);
        ev.slope_up = !step[4] && (step != 5'h00);
    end
endmodule // dpa_phase_eval

// ==== rtl/dpa_aligner.sv ====
// Operation
// - Nine-bit tap selects delay, 0 to 432
// - Delayed clock becomes master digital clock
// - Steer tap until measured phase hits target
// - Phase code 16 means 180 degrees
// - After lock, keep tracking phase drift
// - Out-of-range tap loses lock, optionally restarts
// - Equal guard margins at both range ends
// - One guard step equals eight taps
// - Alternate around initial tap, then check slope
// - Guard hit: one direction, then alternate again
// - Lock drops beyond four, returns within three
// - Both endpoints reached fails; retry bit decides
`timescale 1ns/10ps
module dpa_aligner
    import dpa_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    output logic      [7:0] reg_rdata,
    input  wire logic [4:0] meas_phase,
    input  wire logic       meas_valid,
    output logic      [8:0] delay_tap_setting,
    output logic            phase_locked_flag,
    output logic            phase_lock_lost_flag
);
    // Configuration bytes
    logic [7:0] r_slope, r_run, r_phase, r_tap, r_guard;
    logic [7:0] next_slope, next_run, next_phase, next_tap, next_guard;
    logic       start_req;   // Run bit written high
    logic       stop_req;    // Run bit written low

    // Controller state
    dpa_state_t st, next_st;
    logic [8:0] tap, next_tap_v;        // Tap driving the delay line
    logic [8:0] up_ptr, next_up_ptr;    // Highest tap tried so far
    logic [8:0] dn_ptr, next_dn_ptr;    // Lowest tap tried so far
    logic       go_up, next_go_up;      // Next alternating direction
    logic       inner, next_inner;      // Guards exhausted once
    logic [4:0] prev, next_prev;        // Phase seen before slope step
    logic       locked, next_locked;
    logic       lost, next_lost;
    logic [7:0] rdata, next_rdata;

    // Derived terms
    logic [8:0] init_tap;   // Programmed starting tap
    logic [8:0] margin;     // Guard span in taps
    logic [8:0] lo_lim, hi_lim;
    logic       can_up, can_dn;
    logic       slope_neg, slope_ok, track_en;
    logic       want_up, move_req, oob, fail_evt;

    dpa_eval_if ev ();
    dpa_phase_eval u_eval (.ev(ev));

    assign ev.meas   = meas_phase;
    assign ev.target = r_phase[4:0];
    assign ev.prev   = prev;

    assign init_tap  = {r_tap, r_phase[TAP_LSB_BIT]};
    assign margin    = 9'({r_guard[4:0], 3'b000});
    assign slope_neg = r_slope[SLOPE_NEG_BIT];
    assign track_en  = r_phase[TRACK_BIT];
    assign start_req = reg_wr && (reg_addr == REG_RUN) && reg_wdata[RUN_BIT];
    assign stop_req  = reg_wr && (reg_addr == REG_RUN) && !reg_wdata[RUN_BIT];

    // Register writes; status is read only
    always_comb begin
        next_slope = r_slope;
        next_run   = r_run;
        next_phase = r_phase;
        next_tap   = r_tap;
        next_guard = r_guard;
        if (reg_wr && reg_addr == REG_SLOPE) begin
            next_slope = reg_wdata;
        end else if (reg_wr && reg_addr == REG_RUN) begin
            next_run = reg_wdata;
        end else if (reg_wr && reg_addr == REG_PHASE) begin
            next_phase = reg_wdata;
        end else if (reg_wr && reg_addr == REG_TAP) begin
            next_tap = reg_wdata;
        end else if (reg_wr && reg_addr == REG_GUARD) begin
            next_guard = reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r_slope <= RST_SLOPE;
            r_run   <= RST_RUN;
            r_phase <= RST_PHASE;
            r_tap   <= RST_TAP;
            r_guard <= RST_GUARD;
        end else begin
            r_slope <= next_slope;
            r_run   <= next_run;
            r_phase <= next_phase;
            r_tap   <= next_tap;
            r_guard <= next_guard;
        end
    end

    // Search limits: guards first, the bare endpoints once guards are spent
    always_comb begin
        lo_lim = inner ? 9'h000 : margin;
        hi_lim = inner ? TAP_MAX : 9'(TAP_MAX - margin);
        can_up = up_ptr < hi_lim;
        can_dn = dn_ptr > lo_lim;
        slope_ok = slope_neg ? ev.slope_dn : ev.slope_up;
        // Negative slope: more delay lowers the phase
        want_up  = ev.diff[4] ^ slope_neg;
        move_req = !ev.exact;
        oob      = move_req && (want_up ? (tap == TAP_MAX) : (tap == 9'h000));
        // Same condition as the fail branch below, so retry and stop agree
        fail_evt = (st == ST_SEARCH) && meas_valid && !(ev.exact && tap < TAP_MAX)
                   && !can_up && !can_dn && inner;
    end

    // Controller next state
    always_comb begin
        next_st     = st;
        next_tap_v  = tap;
        next_up_ptr = up_ptr;
        next_dn_ptr = dn_ptr;
        next_go_up  = go_up;
        next_inner  = inner;
        next_prev   = prev;
        next_locked = locked;
        next_lost   = lost;
        if (stop_req) begin
            next_st     = ST_IDLE;
            next_locked = 1'b0;
        end else if (start_req || (fail_evt && r_guard[RETRY_BIT])
                     || (st == ST_TRACK && meas_valid && oob && r_guard[LOSS_BIT])) begin
            // Fresh search from the programmed tap
            next_st     = ST_SEARCH;
            next_tap_v  = init_tap;
            next_up_ptr = init_tap;
            next_dn_ptr = init_tap;
            next_go_up  = 1'b1;
            next_inner  = 1'b0;
            next_locked = 1'b0;
            next_lost   = lost | locked;
        end else if (meas_valid) begin
            case (st)
                ST_SEARCH: begin
                    if (ev.exact && tap < TAP_MAX) begin
                        // Step one tap up to learn the slope
                        next_prev  = meas_phase;
                        next_tap_v = 9'(tap + 9'h001);
                        next_st    = ST_SLOPE;
                    end else if ((go_up || !can_dn) && can_up) begin
                        next_up_ptr = 9'(up_ptr + 9'h001);
                        next_tap_v  = 9'(up_ptr + 9'h001);
                        next_go_up  = 1'b0;
                    end else if (can_dn) begin
                        next_dn_ptr = 9'(dn_ptr - 9'h001);
                        next_tap_v  = 9'(dn_ptr - 9'h001);
                        next_go_up  = 1'b1;
                    end else if (!inner) begin
                        // Both guards hit: alternate again around the start
                        next_inner  = 1'b1;
                        next_up_ptr = init_tap;
                        next_dn_ptr = init_tap;
                    end else begin
                        next_st = ST_FAIL;
                    end
                end
                ST_SLOPE: begin
                    if (slope_ok) begin
                        // Return to the matching tap and start tracking
                        next_tap_v  = 9'(tap - 9'h001);
                        next_st     = ST_TRACK;
                        next_locked = 1'b1;
                        next_lost   = 1'b0;
                    end else begin
                        next_st = ST_SEARCH;
                    end
                end
                ST_TRACK: begin
                    if (ev.far) begin
                        next_locked = 1'b0;
                        next_lost   = lost | locked;
                    end else if (ev.near) begin
                        next_locked = 1'b1;
                        next_lost   = 1'b0;
                    end
                    if (oob) begin
                        // Range end: hold the tap and report the loss
                        next_locked = 1'b0;
                        next_lost   = lost | locked;
                    end else if (move_req && track_en) begin
                        next_tap_v = want_up ? 9'(tap + 9'h001)
                                             : 9'(tap - 9'h001);
                    end
                end
                default: begin
                    next_st = st;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st     <= ST_IDLE;
            tap    <= {RST_TAP, RST_PHASE[TAP_LSB_BIT]};
            up_ptr <= 9'h000;
            dn_ptr <= 9'h000;
            go_up  <= 1'b1;
            inner  <= 1'b0;
            prev   <= 5'h00;
            locked <= 1'b0;
            lost   <= 1'b0;
        end else begin
            st     <= next_st;
            tap    <= next_tap_v;
            up_ptr <= next_up_ptr;
            dn_ptr <= next_dn_ptr;
            go_up  <= next_go_up;
            inner  <= next_inner;
            prev   <= next_prev;
            locked <= next_locked;
            lost   <= next_lost;
        end
    end

    // Read mux; readback bit swaps in the live tap
    always_comb begin
        if (reg_addr == REG_SLOPE) begin
            next_rdata = r_slope;
        end else if (reg_addr == REG_RUN) begin
            next_rdata = r_run;
        end else if (reg_addr == REG_PHASE) begin
            next_rdata = r_run[READ_BIT] ? {tap[0], r_phase[6:0]} : r_phase;
        end else if (reg_addr == REG_TAP) begin
            next_rdata = r_run[READ_BIT] ? tap[8:1] : r_tap;
        end else if (reg_addr == REG_GUARD) begin
            next_rdata = r_guard;
        end else if (reg_addr == REG_STATUS) begin
            next_rdata = {4'h0, st == ST_FAIL, st == ST_TRACK, lost, locked};
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Outputs straight from flops; the tap clocks the digital domain
    assign delay_tap_setting    = tap;
    assign phase_locked_flag    = locked;
    assign phase_lock_lost_flag = lost;
    assign reg_rdata            = rdata;

    // Checks
    a_tap_range: assert property (@(posedge sys_clk) disable iff (!resetn)
        tap <= TAP_MAX) else $error("tap beyond range");
    a_track_step: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st == ST_TRACK && $past(st) == ST_TRACK) |-> (tap == $past(tap)
        || tap == 9'($past(tap) + 9'h001) || 9'(tap + 9'h001) == $past(tap)))
        else $error("track jumped more than one tap");
    a_track_dir: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st == ST_TRACK && meas_valid && move_req && track_en && !oob && !start_req
        && !stop_req) |=> tap == ($past(want_up) ? 9'($past(tap) + 9'h001)
        : 9'($past(tap) - 9'h001))) else $error("track moved wrong way");
    a_lock_search: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st == ST_SEARCH || st == ST_SLOPE) |-> !locked)
        else $error("lock shown while searching");
    a_start_init: assert property (@(posedge sys_clk) disable iff (!resetn)
        start_req |=> (st == ST_SEARCH && tap == $past(init_tap) && !locked))
        else $error("search not from initial tap");
    a_drift_lost: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st == ST_TRACK && meas_valid && ev.far && locked && !start_req && !stop_req)
        |=> (!locked && lost)) else $error("drift did not drop lock");
    a_near_relock: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st == ST_TRACK && meas_valid && ev.near && !oob && !start_req && !stop_req)
        |=> (locked && !lost)) else $error("lock not restored");
    a_guard_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st == ST_SEARCH && $past(st) == ST_SEARCH && !inner && $changed(tap))
        |-> (tap >= margin && tap <= 9'(TAP_MAX - margin)))
        else $error("search crossed guard");
    a_retry_fail: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fail_evt && !stop_req && !start_req)
        |=> (st == ($past(r_guard[RETRY_BIT]) ? ST_SEARCH : ST_FAIL)))
        else $error("failed search mishandled");
    a_loss_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
        (st == ST_TRACK && meas_valid && oob && r_guard[LOSS_BIT] && !stop_req)
        |=> (st == ST_SEARCH && tap == $past(init_tap)))
        else $error("loss did not restart");
    c_locked: cover property (@(posedge sys_clk) disable iff (!resetn)
        st == ST_SLOPE ##1 st == ST_TRACK);
    c_lost: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(lost));
    c_inner: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(inner));
    c_fail: cover property (@(posedge sys_clk) disable iff (!resetn) st == ST_FAIL);
endmodule // dpa_aligner

// ==== verification/dpa_phase_model.sv ====
`timescale 1ns/10ps
// Analog clock path: phase of the delayed digital clock against the core clock
module dpa_phase_model (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [8:0] delay_tap_setting,  // Tap now in the delay line
    input  wire logic       slope_pos,          // Phase rises with the tap
    input  wire logic [4:0] offset,             // Phase seen at tap zero
    input  wire logic       stuck,              // Phase never moves: no lock possible
    input  wire logic [1:0] gap,                // Idle cycles between samples
    output logic      [4:0] meas_phase,
    output logic            meas_valid
);
    logic [1:0] gap_cnt;  // Cycles since the last sample
    logic [4:0] phase;    // Phase at the current tap

    // Sawtooth: one phase code per eight taps, 16 codes per half turn
    always_comb begin
        if (stuck) begin
            phase = offset;
        end else if (slope_pos) begin
            phase = offset + 5'(delay_tap_setting[7:3]);
        end else begin
            phase = offset - 5'(delay_tap_setting[7:3]);
        end
    end

    // Off-sample cycles show the inverse, so a stale value never passes
    assign meas_phase = meas_valid ? phase : ~phase;

    // Sample strobe; gap of zero samples every cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_cnt    <= 2'h0;
            meas_valid <= 1'b0;
        end else if (gap_cnt >= gap) begin
            gap_cnt    <= 2'h0;
            meas_valid <= 1'b1;
        end else begin
            gap_cnt    <= gap_cnt + 2'h1;
            meas_valid <= 1'b0;
        end
    end
endmodule // dpa_phase_model

// ==== verification/dac_clock_phase_aligner_bench.sv ====
`timescale 1ns/10ps
module dac_clock_phase_aligner_bench
    import dpa_pkg::*;
;
    logic       sys_clk;
    logic       resetn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic [7:0] reg_rdata;
    logic [4:0] meas_phase;
    logic       meas_valid;
    logic [8:0] delay_tap_setting;
    logic       phase_locked_flag;
    logic       phase_lock_lost_flag;
    logic       slope_pos;   // Model slope
    logic [4:0] offset;      // Model phase at tap zero
    logic       stuck;       // Model phase never moves
    logic [1:0] gap;         // Model sample spacing
    logic [8:0] tap_min;     // Lowest tap seen
    logic [8:0] tap_max;     // Highest tap seen
    int         err_count;
    int         n_checks;
    // Recommended slope and phase per clock rate, {positive, phase}
    localparam logic [5:0] TABLE [9] = '{6'h06, 6'h04, 6'h25, 6'h28, 6'h2C,
                                         6'h0C, 6'h0A, 6'h08, 6'h06};
    localparam logic [7:0] ADDRS [7] = '{REG_SLOPE, REG_RUN, REG_PHASE, REG_TAP,
                                         REG_GUARD, REG_STATUS, 8'h31};
    localparam logic [7:0] RSTS [7]  = '{RST_SLOPE, RST_RUN, RST_PHASE, RST_TAP,
                                         RST_GUARD, 8'h00, 8'h00};

    dpa_aligner dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .meas_phase(meas_phase), .meas_valid(meas_valid),
        .delay_tap_setting(delay_tap_setting), .phase_locked_flag(phase_locked_flag),
        .phase_lock_lost_flag(phase_lock_lost_flag));
    dpa_phase_model path (.sys_clk(sys_clk), .resetn(resetn),
        .delay_tap_setting(delay_tap_setting), .slope_pos(slope_pos), .offset(offset),
        .stuck(stuck), .gap(gap), .meas_phase(meas_phase), .meas_valid(meas_valid));

    // Free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Single compare point
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Let the edge's updates land before sampling
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // One-cycle write strobe, launched at an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // Read data is registered: one edge to present the address, one to capture
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        tick(2);
        v = reg_rdata;
    endtask

    // Bounded wait on the lock flag; a timeout shows up as a mismatch
    task automatic wait_lock(input logic want, input int lim);
        for (int i = 0; i < lim && phase_locked_flag !== want; i++) tick(1);
        check(32'(phase_locked_flag), 32'(want));
    endtask

    // Expected phase at a tap, from the model's characteristic
    function automatic logic [4:0] phase_of(input logic [8:0] t);
        return slope_pos ? offset + 5'(t[7:3]) : offset - 5'(t[7:3]);
    endfunction

    // Tap never leaves the delay line; sampled mid-cycle, once settled
    always @(negedge sys_clk) begin
        if (resetn) begin
            check(32'(delay_tap_setting <= TAP_MAX), 32'h1);
            if (delay_tap_setting < tap_min) tap_min <= delay_tap_setting;
            if (delay_tap_setting > tap_max) tap_max <= delay_tap_setting;
        end
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] v;
        logic [4:0] tgt;
        logic [4:0] g;
        logic [8:0] lo;
        logic [8:0] hi;
        logic [8:0] lk;
        logic [7:0] w;
        resetn    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        slope_pos = 1'b0;
        offset    = 5'h00;
        stuck     = 1'b0;
        gap       = 2'h0;
        err_count = 0;
        n_checks  = 0;
        tap_min   = TAP_MAX;
        tap_max   = 9'h000;
        void'($urandom(32'h9f7e));
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        tick(1);
        check(32'(delay_tap_setting), 32'h0000_00D8);
        // Reset values, read-only status, unmapped address
        for (int i = 0; i < 7; i++) begin
            rd(ADDRS[i], v);
            check(32'(v), 32'(RSTS[i]));
        end
        wr(REG_STATUS, 8'hFF);
        rd(REG_STATUS, v);
        check(32'(v), 32'h0000_0000);
        v = 8'($urandom);
        wr(REG_TAP, v);
        rd(REG_TAP, w);
        check(32'(w), 32'(v));
        // Lock on every recommended slope and phase, random guard and match tap
        for (int i = 0; i < 9; i++) begin
            // Stop first, so the new slope and offset never land under a live tracking loop
            wr(REG_RUN, 8'h00);
            slope_pos = TABLE[i][5];
            tgt = TABLE[i][4:0];
            g  = 5'(10 + $urandom_range(5));
            lo = 9'(g) << GUARD_SHIFT;
            hi = TAP_MAX - lo;
            lk = (lo + 9'h008 + 9'($urandom_range(int'(hi - lo) - 32))) | 9'h007;
            offset = slope_pos ? tgt - 5'(lk[7:3]) : tgt + 5'(lk[7:3]);
            gap = 2'($urandom_range(2));
            wr(REG_SLOPE, {~slope_pos, 7'h00});
            wr(REG_PHASE, {3'b010, tgt});
            wr(REG_TAP, RST_TAP);
            wr(REG_GUARD, {3'b110, g});
            wr(REG_RUN, 8'h01);
            check(32'(delay_tap_setting), 32'h0000_00D8);
            check(32'(phase_locked_flag), 32'h0);
            wait_lock(1'b1, 20000);
            check(32'(phase_of(delay_tap_setting)), 32'(tgt));
            check(32'(delay_tap_setting >= lo && delay_tap_setting <= hi), 32'h1);
            rd(REG_STATUS, v);
            check(32'(v), 32'h0000_0005);
            // Drift of four keeps lock
            @(posedge sys_clk);
            offset <= offset + 5'h04;
            tick(4);
            check(32'(phase_locked_flag), 32'h1);
            tick(600);
            check(32'(phase_of(delay_tap_setting)), 32'(tgt));
            // Drift of five drops lock, tracking wins it back
            @(posedge sys_clk);
            offset <= offset + 5'h05;
            wait_lock(1'b0, 40);
            check(32'(phase_lock_lost_flag), 32'h1);
            wait_lock(1'b1, 2000);
            check(32'(phase_lock_lost_flag), 32'h0);
            tick(600);
            check(32'(phase_of(delay_tap_setting)), 32'(tgt));
        end
        // Drift past the top tap: restart_on_loss sends the search back to the start
        wr(REG_GUARD, 8'hEB);
        for (int k = 0; k < 16 && phase_lock_lost_flag !== 1'b1; k++) begin
            @(posedge sys_clk);
            offset <= offset + 5'h04;
            for (int j = 0; j < 200 && phase_lock_lost_flag !== 1'b1; j++) begin
                tick(1);
            end
        end
        check(32'(phase_lock_lost_flag), 32'h1);
        check(32'(delay_tap_setting), 32'h0000_00D8);
        check(32'(phase_locked_flag), 32'h0);
        wait_lock(1'b1, 20000);
        check(32'(phase_lock_lost_flag), 32'h0);
        // No match anywhere: search runs to both endpoints, then stops
        wr(REG_RUN, 8'h00);
        stuck  = 1'b1;
        offset = 5'h16;
        wr(REG_PHASE, RST_PHASE);
        wr(REG_GUARD, 8'h8B);
        tap_min = TAP_MAX;
        tap_max = 9'h000;
        wr(REG_RUN, 8'h01);
        v = 8'h00;
        for (int k = 0; k < 300 && v[3] !== 1'b1; k++) begin
            tick(20);
            rd(REG_STATUS, v);
        end
        check(32'(v), 32'h0000_0008);
        check(32'(tap_min), 32'h0000_0000);
        check(32'(tap_max), 32'(TAP_MAX));
        lk = delay_tap_setting;
        tick(50);
        check(32'(delay_tap_setting), 32'(lk));
        // Live readback of the tap in use
        wr(REG_RUN, 8'h08);
        rd(REG_TAP, v);
        check(32'(v), 32'(delay_tap_setting[8:1]));
        rd(REG_PHASE, v);
        check(32'(v[7]), 32'(delay_tap_setting[0]));
        // Retry set: a failed search starts over instead of stopping
        wr(REG_GUARD, RST_GUARD);
        wr(REG_RUN, 8'h01);
        tick(3000);
        rd(REG_STATUS, v);
        check(32'(v), 32'h0000_0000);
        tally_and_finish();
    end
endmodule // dac_clock_phase_aligner_bench
